/* hdl/cic_pkg.sv */
// constants, types and register map of the core interrupt control block
package cic_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PORT_FLAGS = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;
  // bit positions inside the control register
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_GROUP_IRQ_ENABLE = 6;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_IOC_EN = 3;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_IOC_FLAG = 0;
  // sticky event status bits
  localparam int STS_W = 4;
  localparam int STS_TMR = 0;
  localparam int STS_EXT = 1;
  localparam int STS_IOC = 2;
  localparam int STS_VEC = 3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PORT_FLAGS_RST = 8'h00;
  localparam logic [3:0] STS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // instruction cycle timing, vector address and port width
  localparam int QPHASES = 4;
  localparam logic [1:0] QPHASE_Q1 = 2'h0;
  localparam int NOP_CYCLES = 2;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int PORT_W = 8;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout, most significant field first
  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_group_irq_enable;
    logic tmr_en;
    logic ext_en;
    logic ioc_en;
    logic tmr_flag;
    logic ext_flag;
    logic ioc_flag;
  } cic_ctrl_type;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_PORT_FLAGS,
    SEL_STATUS,
    SEL_MASK,
    SEL_STATE,
    SEL_NONE
  } cic_sel_type;

  // vectoring sequence states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FINISH,
    ST_IDLE_INS,
    ST_VECTOR
  } cic_state_type;
endpackage

/* hdl/cic_sync.sv */
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module cic_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  // one chain per bit, only the second stage is visible
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_reg[g] <= 1'b0;
        sync_o[g] <= 1'b0;
      end else begin
        meta_reg[g] <= async_i[g];
        sync_o[g] <= meta_reg[g];
      end
    end
  end
endmodule

/* hdl/cic_qphase.sv */
// quarter-phase divider of the instruction cycle
`timescale 1ns/1ps
module cic_qphase
  import cic_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  output logic [1:0] qphase_o,
  output logic q1_o
);
  // free running phase count, q1 is phase zero
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qphase_o <= QPHASE_Q1;
    end else begin
      qphase_o <= qphase_o + 2'h1;
    end
  end

  // one-cycle enable during the first quarter-phase
  assign q1_o = (qphase_o == QPHASE_Q1);
endmodule

/* hdl/cic_top.sv */
// core interrupt control: enables, flags, vectoring and register slave
// Summary of operation
// - bit 7 global enable lets enabled sources interrupt the core, and blocks all when 0.
// - bit 6 peripheral-group enable passes peripheral requests when 1 and suppresses them when 0.
// - bits 5, 4, 3 enable the timer overflow, external pin and pin-change interrupts.
// - bit 2 timer overflow flag sets on a timer count overflow or when written with 1, and clears when written with 0.
// - bit 1 external pin flag sets on an event on the interrupt pin.
// - bit 0 pin-change summary reads 1 while any monitored pin change flag is set.
// - the summary ignores writes and clears only when all per-pin change flags are cleared.
// - every flag sets on its event whatever its own enable and the global enable.
// - enabled sources wake the core from sleep.
`timescale 1ns/1ps
module cic_top
  import cic_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [DATA_W-1:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic timer_overflow_i,
  input wire logic ext_pin_i,
  input wire logic [PORT_W-1:0] port_pins_i,
  input wire logic periph_irq_i,
  input wire logic sleep_i,
  input wire logic instr_done_i,
  output logic core_irq_req_o,
  output logic wake_o,
  output logic insert_idle_o,
  output logic vector_load_o,
  output logic [14:0] vector_addr_o,
  output logic irq_o
);
  cic_ctrl_type ctrl_reg;
  logic [PORT_W-1:0] port_change_flags_reg;
  logic [STS_W-1:0] status_reg;
  logic [STS_W-1:0] mask_reg;
  cic_state_type state_reg;
  logic nop_cnt_reg;
  logic vector_load_reg;
  logic have_aw_reg, have_w_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [1:0] qphase;
  logic q1;
  logic ext_sync;
  logic ext_prev_reg;
  logic [PORT_W-1:0] pins_sync;
  logic [PORT_W-1:0] pins_prev_reg;
  logic ext_event;
  logic [PORT_W-1:0] pin_change;
  logic ioc_summary;
  logic wr_fire, wr_ctrl, wr_port, pending;
  cic_sel_type wr_sel, rd_sel;

  // address decode shared by reads and writes
  function automatic cic_sel_type reg_sel(input logic [ADDR_W-1:0] addr);
    if (addr == OFS_CTRL) begin
      reg_sel = SEL_CTRL;
    end else if (addr == OFS_PORT_FLAGS) begin
      reg_sel = SEL_PORT_FLAGS;
    end else if (addr == OFS_STATUS) begin
      reg_sel = SEL_STATUS;
    end else if (addr == OFS_MASK) begin
      reg_sel = SEL_MASK;
    end else if (addr == OFS_STATE) begin
      reg_sel = SEL_STATE;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  cic_qphase u_qphase (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .qphase_o(qphase),
    .q1_o(q1)
  );

  cic_sync #(.WIDTH(1)) u_ext_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_pin_i),
    .sync_o(ext_sync)
  );

  cic_sync #(.WIDTH(PORT_W)) u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(port_pins_i),
    .sync_o(pins_sync)
  );

  // previous pin levels for edge and change detection
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_prev_reg <= 1'b0;
      pins_prev_reg <= '0;
    end else begin
      ext_prev_reg <= ext_sync;
      pins_prev_reg <= pins_sync;
    end
  end

  // event detection and decoded write strobes
  assign ext_event = ext_sync & ~ext_prev_reg; // rising edge
  assign pin_change = pins_sync ^ pins_prev_reg;
  assign ioc_summary = |port_change_flags_reg;
  assign wr_fire = have_aw_reg & have_w_reg & ~bvalid_reg;
  assign wr_sel = reg_sel(awaddr_reg);
  assign rd_sel = reg_sel(s_axi_araddr_i);
  assign wr_ctrl = wr_fire & wstrb0_reg & (wr_sel == SEL_CTRL);
  assign wr_port = wr_fire & wstrb0_reg & (wr_sel == SEL_PORT_FLAGS);

  // control bits and flags; events win over a clearing write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[7:1] <= wdata_reg[7:1];
      end
      if (vector_load_reg) begin
        ctrl_reg.global_irq_enable <= 1'b0;
      end
      if (timer_overflow_i) begin
        ctrl_reg.tmr_flag <= 1'b1;
      end
      if (ext_event) begin
        ctrl_reg.ext_flag <= 1'b1;
      end
      ctrl_reg.ioc_flag <= 1'b0; // summary is not stored
    end
  end

  // per-pin change flags, cleared by writing 0
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_change_flags_reg <= PORT_FLAGS_RST;
    end else if (wr_port) begin
      port_change_flags_reg <= (port_change_flags_reg & wdata_reg) | pin_change;
    end else begin
      port_change_flags_reg <= port_change_flags_reg | pin_change;
    end
  end

  // request gating toward the core
  assign pending = (ctrl_reg.tmr_flag & ctrl_reg.tmr_en)
    | (ctrl_reg.ext_flag & ctrl_reg.ext_en)
    | (ioc_summary & ctrl_reg.ioc_en)
    | (periph_irq_i & ctrl_reg.peripheral_group_irq_enable);
  assign core_irq_req_o = pending & ctrl_reg.global_irq_enable;
  assign wake_o = pending & sleep_i;

  // vectoring sequence: sample in q1, finish, idle, jump
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      nop_cnt_reg <= 1'b0;
      vector_load_reg <= 1'b0;
    end else begin
      vector_load_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (q1 && core_irq_req_o) begin
            state_reg <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          if (instr_done_i) begin
            state_reg <= ST_IDLE_INS;
            nop_cnt_reg <= 1'b0;
          end
        end
        ST_IDLE_INS: begin
          if (q1) begin
            if (nop_cnt_reg == 1'(NOP_CYCLES - 1)) begin
              state_reg <= ST_VECTOR;
            end else begin
              nop_cnt_reg <= 1'b1;
            end
          end
        end
        ST_VECTOR: begin
          vector_load_reg <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign insert_idle_o = (state_reg == ST_IDLE_INS);
  assign vector_load_o = vector_load_reg;
  assign vector_addr_o = IRQ_VECTOR;

  // sticky event status, write one to clear, event wins
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_reg <= STS_RST;
      mask_reg <= MASK_RST;
    end else begin
      if (wr_fire && wstrb0_reg && wr_sel == SEL_MASK) begin
        mask_reg <= wdata_reg[STS_W-1:0];
      end
      status_reg <= (status_reg
        & ~((wr_fire && wstrb0_reg && wr_sel == SEL_STATUS) ? wdata_reg[STS_W-1:0] : 4'h0))
        | {vector_load_reg, |pin_change, ext_event, timer_overflow_i};
    end
  end

  assign irq_o = |(status_reg & mask_reg);

  // write address and data channels, taken in either order
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      have_aw_reg <= 1'b0;
      have_w_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        have_aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        have_w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i[7:0];
        wstrb0_reg <= s_axi_wstrb_i[0];
      end
      if (wr_fire) begin
        have_aw_reg <= 1'b0;
        have_w_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = ~have_aw_reg & ~bvalid_reg;
  assign s_axi_wready_o = ~have_w_reg & ~bvalid_reg;
  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // read channel, data captured at the address handshake
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      if (rd_sel == SEL_CTRL) begin
        rdata_reg <= {24'h000000, ctrl_reg[7:1], ioc_summary};
      end else if (rd_sel == SEL_PORT_FLAGS) begin
        rdata_reg <= {24'h000000, port_change_flags_reg};
      end else if (rd_sel == SEL_STATUS) begin
        rdata_reg <= {28'h0000000, status_reg};
      end else if (rd_sel == SEL_MASK) begin
        rdata_reg <= {28'h0000000, mask_reg};
      end else if (rd_sel == SEL_STATE) begin
        rdata_reg <= {26'h0, qphase, state_reg, pending, core_irq_req_o};
      end else begin
        rdata_reg <= '0;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready_i) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_arready_o = ~rvalid_reg;
  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

  // checks on enables, flags and the vectoring sequence
  a_global_blocks: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ctrl_reg.global_irq_enable |-> !core_irq_req_o) else $error("request with global enable clear");
  a_group_gates: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (core_irq_req_o && !ctrl_reg.peripheral_group_irq_enable) |-> (ctrl_reg.tmr_flag && ctrl_reg.tmr_en)
      || (ctrl_reg.ext_flag && ctrl_reg.ext_en) || (ioc_summary && ctrl_reg.ioc_en))
    else $error("peripheral request passed with group enable clear");
  a_source_enable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ctrl_reg.global_irq_enable && ctrl_reg.tmr_en && ctrl_reg.tmr_flag) |-> core_irq_req_o)
    else $error("enabled timer flag gave no request");
  a_timer_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    timer_overflow_i |=> ctrl_reg.tmr_flag && status_reg[STS_TMR])
    else $error("timer overflow did not set its flag");
  a_ext_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(ext_sync) |=> ctrl_reg.ext_flag) else $error("pin edge did not set its flag");
  a_summary_follows: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (|pin_change) |=> ioc_summary ##0 (port_change_flags_reg != 8'h00))
    else $error("pin change did not raise the summary");
  a_summary_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(ioc_summary) |-> $past(wr_port)) else $error("summary cleared without a flag write");
  a_vector_timing: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    vector_load_o |-> ($past(insert_idle_o, 2) && $past(insert_idle_o, 6)) ##1 !ctrl_reg.global_irq_enable)
    else $error("vector without idle cycles");
  a_sample_in_q1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_reg == ST_IDLE) ##1 (state_reg == ST_FINISH) |-> $past(q1))
    else $error("request sampled outside q1");
  a_sleep_wake: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (sleep_i && ctrl_reg.ext_en && ctrl_reg.ext_flag) |-> wake_o)
    else $error("enabled source did not wake the core");
endmodule

/* verif/cic_core_model.sv */
// core side model: instruction completions, idle cycles and vector loads
`timescale 1ns/1ps
module cic_core_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic insert_idle_i,
  input wire logic vector_load_i,
  input wire logic [14:0] vector_addr_i,
  output logic instr_done_o,
  output logic [14:0] pc_o,
  output int idles_o,
  output int loads_o
);
  logic [1:0] cyc_reg;

  // one single-cycle instruction completes every instruction cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_reg <= 2'h0;
      instr_done_o <= 1'b0;
    end else begin
      cyc_reg <= cyc_reg + 2'h1;
      instr_done_o <= (cyc_reg == 2'h3);
    end
  end

  // program counter loads and idle cycles executed
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_o <= 15'h0000;
      idles_o <= 0;
      loads_o <= 0;
    end else begin
      if (insert_idle_i) idles_o <= idles_o + 1;
      if (vector_load_i) begin
        pc_o <= vector_addr_i;
        loads_o <= loads_o + 1;
      end
    end
  end
endmodule

/* verif/cic_top_bench.sv */
// self-checking bench of the core interrupt control block
`timescale 1ns/1ps
module cic_top_bench;
  import cic_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tmr_ev = 1'b0, ext_pin = 1'b0, periph = 1'b0, sleep = 1'b0;
  logic [7:0] pins = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, instr_done, req, wake, idle, vload, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [14:0] vaddr, pc;
  int idles, loads, n_errors = 0, checks_done = 0, cycles = 0;
  logic [7:0] tab_ctrl [7] = '{8'hA4, 8'h24, 8'h92, 8'h88, 8'hC0, 8'h80, 8'hA0};
  logic [6:0] tab_per = 7'b0110000;
  logic [6:0] tab_req = 7'b0011101;

  always #20 mclk_i = ~mclk_i;

  cic_top uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .timer_overflow_i(tmr_ev), .ext_pin_i(ext_pin),
    .port_pins_i(pins), .periph_irq_i(periph), .sleep_i(sleep), .instr_done_i(instr_done),
    .core_irq_req_o(req), .wake_o(wake), .insert_idle_o(idle), .vector_load_o(vload),
    .vector_addr_o(vaddr), .irq_o(irq));

  cic_core_model core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .insert_idle_i(idle),
    .vector_load_i(vload), .vector_addr_i(vaddr), .instr_done_o(instr_done), .pc_o(pc),
    .idles_o(idles), .loads_o(loads));

  // closing report and verdict
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // bus write: address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic a_hs, w_hs, b_hs;
    @(posedge mclk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hs = 1'b0;
    while (!b_hs) begin
      @(negedge mclk_i);
      a_hs = awvalid && awready;
      w_hs = wvalid && wready;
      b_hs = bvalid && bready;
      resp = bresp;
      @(posedge mclk_i);
      if (a_hs) awvalid <= 1'b0;
      if (w_hs) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask

  // bus read into rd and resp
  task automatic rd_t(input logic [7:0] a);
    logic a_hs, r_hs;
    @(posedge mclk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hs = 1'b0;
    while (!r_hs) begin
      @(negedge mclk_i);
      a_hs = arvalid && arready;
      r_hs = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge mclk_i);
      if (a_hs) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask

  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd_t(a);
    check(what, exp, rd);
  endtask

  // waits for the vector load and checks what the core saw
  task automatic wait_vec();
    int l0, i0, n;
    l0 = loads;
    i0 = idles;
    n = 0;
    while (loads == l0 && n < 200) begin
      @(negedge mclk_i);
      n++;
    end
    check("vector loads", 32'(l0 + 1), 32'(loads));
    check("idle before vector", 32'h1, 32'(idles > i0));
    check("program counter", 32'h00000004, {17'h0, pc});
  endtask

  task automatic pulse_timer();
    @(posedge mclk_i);
    tmr_ev <= 1'b1;
    @(posedge mclk_i);
    tmr_ev <= 1'b0;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    chk_rd("control reset", OFS_CTRL, 32'h0);
    chk_rd("status reset", OFS_STATUS, 32'h0);
    chk_rd("mask reset", OFS_MASK, 32'h0);
    $display("test reset values done");
    // events with every enable off
    ext_pin <= 1'b1;
    pins <= 8'h08;
    pulse_timer();
    repeat (8) @(posedge mclk_i);
    chk_rd("flags with enables off", OFS_CTRL, 32'h07);
    check("request with enables off", 32'h0, {31'h0, req});
    chk_rd("port change flags", OFS_PORT_FLAGS, 32'h08);
    wr(OFS_CTRL, 8'h00);
    chk_rd("summary ignores writes", OFS_CTRL, 32'h01);
    $display("test event flags done");
    // enable gating and vectoring per source
    for (int i = 0; i < 7; i++) begin
      periph <= tab_per[i];
      wr(OFS_CTRL, tab_ctrl[i]);
      check("core request", {31'h0, tab_req[i]}, {31'h0, req});
      if (tab_req[i]) begin
        wait_vec();
        chk_rd("control after vector", OFS_CTRL, {24'h0, tab_ctrl[i] & 8'h7F | 8'h01});
      end
      periph <= 1'b0;
      wr(OFS_CTRL, 8'h00);
    end
    wr(OFS_PORT_FLAGS, 8'h00);
    chk_rd("summary after port clear", OFS_CTRL, 32'h00);
    $display("test gating and vectoring done");
    // status, mask and interrupt line
    wr(OFS_STATUS, 8'h0F);
    chk_rd("status cleared", OFS_STATUS, 32'h0);
    pulse_timer();
    repeat (2) @(posedge mclk_i);
    chk_rd("status timer event", OFS_STATUS, 32'h1);
    check("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 8'h01);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wr(OFS_STATUS, 8'h01);
    check("irq after clear", 32'h0, {31'h0, irq});
    wr(OFS_MASK, 8'h00);
    $display("test interrupt line done");
    // wake from sleep
    sleep <= 1'b1;
    wr(OFS_CTRL, 8'h04);
    check("wake without enable", 32'h0, {31'h0, wake});
    wr(OFS_CTRL, 8'h24);
    check("wake with enable", 32'h1, {31'h0, wake});
    rd_t(OFS_STATE);
    check("state pending without global", 32'h2, rd & 32'h0F);
    wr(OFS_CTRL, 8'h00);
    sleep <= 1'b0;
    $display("test wake done");
    // unmapped address
    wr(8'h14, 8'hFF);
    check("unmapped write response", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rd_t(8'h14);
    check("unmapped read response", {30'h0, RESP_SLVERR}, {30'h0, resp});
    check("unmapped read data", 32'h0, rd);
    $display("test unmapped done");
    results();
  end
endmodule
